//--- apo_param_override.sv
/*
  Auto-tuning parameter override: stores the loop, filter and switching parameters
  written by software and rewrites them from the stiffness setting and fixed values
  while auto-tuning is on, and masks the observers without touching their settings.
  Assumes one control clock, an asynchronous active-low reset and a register master
  that issues one-cycle strobes and takes read data in the cycle after the strobe.
*/
`timescale 1ns/100ps
module apo_param_override
  import apo_pkg::*;
(
  // Clock and reset.
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  // Register port.
  input  apo_bus_s               i_bus,
  output logic [APO_DW-1:0]      o_rdata,
  // Effective parameters for the control loops.
  output apo_prm_t               o_prm,
  output logic [7:0]             o_fexp_eff,
  output logic [APO_DW-1:0]      o_dob_gain,
  output logic [APO_DW-1:0]      o_dob_filt,
  output apo_obs_s               o_obs,
  output logic                   o_auto_en
);

  logic [7:0]        mode_q;
  logic [APO_SW-1:0] stiff_q;
  apo_ctrl_s         ctrl_q;
  logic [7:0]        fexp_q;
  logic [7:0]        fexp_eff_q;
  logic [15:0]       dobg_q;
  logic [15:0]       dobf_q;
  apo_obs_s          obs_q;
  logic              auto_en_q;
  logic [15:0]       rdata_q;
  apo_prm_t          prm_q;
  apo_prm_t          frc_val;
  logic [APO_NPRM-1:0] frc_en;
  apo_gain_s         gain;
  logic              auto_en_d;
  logic              prm_hit;
  logic [4:0]        prm_ix;
  logic [15:0]       rd_mux;

  // Saturates a written value to the legal range of its entry.
  function automatic logic [15:0] apo_clamp(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
    apo_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  apo_gain_table u_table (
    .i_stiff (stiff_q),
    .o_gain  (gain)
  );

  assign auto_en_d = (mode_q != APO_MODE_RST);
  assign prm_ix    = i_bus.addr[4:0];
  assign prm_hit   = (i_bus.addr[7:5] == APO_OFS_PRM[7:5]) && (prm_ix <= 5'(APO_IX_LAST));

  // Mode, stiffness and control settings.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q  <= APO_MODE_RST;
      stiff_q <= APO_STIFF_RST;
      ctrl_q  <= APO_CTRL_RST;
    end else if (i_bus.wr) begin
      if (i_bus.addr == APO_OFS_MODE) begin
        mode_q <= i_bus.wdata[7:0];
      end
      if (i_bus.addr == APO_OFS_STIFF) begin
        stiff_q <= i_bus.wdata[APO_SW-1:0];
      end
      if (i_bus.addr == APO_OFS_CTRL) begin
        ctrl_q <= i_bus.wdata[3:0];
      end
    end
  end

  // Override values; each group has its own enabling condition.
  always_comb begin
    frc_en  = '0;
    frc_val = '0;
    if (auto_en_d && ctrl_q.stiff_valid) begin
      frc_en[APO_IX_POS1]  = 1'b1;
      frc_val[APO_IX_POS1] = gain.pos1;
      frc_en[APO_IX_VEL1]  = 1'b1;
      frc_val[APO_IX_VEL1] = gain.vel1;
      frc_en[APO_IX_INT1]  = 1'b1;
      frc_val[APO_IX_INT1] = gain.int1;
      frc_en[APO_IX_FLT1]  = 1'b1;
      frc_val[APO_IX_FLT1] = gain.flt1;
      frc_en[APO_IX_POS2]  = 1'b1;
      frc_val[APO_IX_POS2] = gain.pos2;
      frc_en[APO_IX_VEL2]  = 1'b1;
      frc_val[APO_IX_VEL2] = gain.vel1;
      frc_en[APO_IX_INT2]  = 1'b1;
      frc_val[APO_IX_INT2] = APO_INT2_FIX;
      frc_en[APO_IX_FLT2]  = 1'b1;
      frc_val[APO_IX_FLT2] = gain.flt1;
    end
    if (auto_en_d && ctrl_q.fixed_valid) begin
      frc_en[APO_IX_VDF1]  = 1'b1;
      frc_val[APO_IX_VDF1] = APO_ZERO;
      frc_en[APO_IX_VDF2]  = 1'b1;
      frc_val[APO_IX_VDF2] = APO_ZERO;
      frc_en[APO_IX_TFFG]  = 1'b1;
      frc_val[APO_IX_TFFG] = APO_ZERO;
      frc_en[APO_IX_TFFF]  = 1'b1;
      frc_val[APO_IX_TFFF] = APO_ZERO;
      frc_en[APO_IX_VFFG]  = 1'b1;
      frc_val[APO_IX_VFFG] = APO_FIX_VFFG;
      frc_en[APO_IX_VFFF]  = 1'b1;
      frc_val[APO_IX_VFFF] = APO_FIX_VFFF;
    end
    // The position switching mode is forced whether or not current settings are kept.
    if (auto_en_d) begin
      frc_en[APO_IX_PMOD]  = 1'b1;
      frc_val[APO_IX_PMOD] = ctrl_q.gsw_en ? APO_GSW_MOD_ON : APO_ZERO;
    end
    if (auto_en_d && !ctrl_q.keep_cur) begin
      frc_en[APO_IX_SEL2]  = 1'b1;
      frc_val[APO_IX_SEL2] = APO_GSW_SEL2;
      frc_en[APO_IX_PDLY]  = 1'b1;
      frc_val[APO_IX_PDLY] = APO_GSW_DLY;
      frc_en[APO_IX_PLVL]  = 1'b1;
      frc_val[APO_IX_PLVL] = APO_GSW_LVL;
      frc_en[APO_IX_PHYS]  = 1'b1;
      frc_val[APO_IX_PHYS] = APO_GSW_HYS;
      frc_en[APO_IX_PTIM]  = 1'b1;
      frc_val[APO_IX_PTIM] = APO_GSW_TIM;
      frc_en[APO_IX_LAST:APO_IX_VMOD] = '1;
    end
  end

  // One register per entry; all forced entries change on the same edge.
  for (genvar gi = 0; gi < APO_NPRM; gi++) begin : g_prm
    always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
        prm_q[gi] <= APO_PRM_MIN[gi];
      end else if (frc_en[gi]) begin
        prm_q[gi] <= frc_val[gi];
      end else if (i_bus.wr && prm_hit && (prm_ix == 5'(gi))) begin
        prm_q[gi] <= apo_clamp(i_bus.wdata, APO_PRM_MIN[gi],
                               APO_PRM_MAX[gi]);
      end
    end
  end

  // Observer settings; writes are taken even while the observer is masked.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fexp_q <= APO_FEXP_RST;
      dobg_q <= APO_DOBG_RST;
      dobf_q <= APO_DOBF_RST;
    end else if (i_bus.wr) begin
      if (i_bus.addr == APO_OFS_FEXP) begin
        fexp_q <= i_bus.wdata[7:0];
      end
      if (i_bus.addr == APO_OFS_DOBG) begin
        dobg_q <= ($signed(i_bus.wdata) < APO_DOBG_MIN) ? APO_DOBG_MIN :
                  (($signed(i_bus.wdata) > APO_DOBG_MAX) ? APO_DOBG_MAX : i_bus.wdata);
      end
      if (i_bus.addr == APO_OFS_DOBF) begin
        dobf_q <= apo_clamp(i_bus.wdata, APO_DOBF_MIN, APO_DOBF_MAX);
      end
    end
  end

  // Effective observer view, derived from the stored setting.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fexp_eff_q <= APO_FEXP_RST;
      obs_q      <= '0;
      auto_en_q  <= 1'b0;
    end else begin
      auto_en_q  <= auto_en_d;
      fexp_eff_q <= auto_en_d ? (fexp_q & 8'hFC) : fexp_q;
      obs_q.ivob_en <= fexp_q[APO_FEXP_IVOB] && !auto_en_d;
      obs_q.dob_en  <= fexp_q[APO_FEXP_DOB] && !auto_en_d;
    end
  end

  // Read path; unmapped offsets read as zero.
  always_comb begin
    rd_mux = '0;
    if (prm_hit) begin
      rd_mux = prm_q[prm_ix];
    end else begin
      unique case (i_bus.addr)
        APO_OFS_MODE:  rd_mux = {8'h00, mode_q};
        APO_OFS_STIFF: rd_mux = {11'h000, stiff_q};
        APO_OFS_CTRL:  rd_mux = {12'h000, ctrl_q};
        APO_OFS_STAT:  rd_mux = {5'h00, auto_en_q, obs_q, fexp_eff_q};
        APO_OFS_FEXP:  rd_mux = {8'h00, fexp_q};
        APO_OFS_DOBG:  rd_mux = dobg_q;
        APO_OFS_DOBF:  rd_mux = dobf_q;
        default:       rd_mux = '0;
      endcase
    end
  end

  // Read data stand for one cycle after the strobe and are zero otherwise.
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= i_bus.rd ? rd_mux : 16'h0000;
    end
  end

  assign o_rdata    = rdata_q;
  assign o_prm      = prm_q;
  assign o_fexp_eff = fexp_eff_q;
  assign o_dob_gain = dobg_q;
  assign o_dob_filt = dobf_q;
  assign o_obs      = obs_q;
  assign o_auto_en  = auto_en_q;

  sequence s_stiff_req;
    auto_en_d && ctrl_q.stiff_valid;
  endsequence
  sequence s_fixed_req;
    auto_en_d && ctrl_q.fixed_valid;
  endsequence
  sequence s_fixed_done;
    (prm_q[APO_IX_VDF1] == 16'h0000) && (prm_q[APO_IX_VDF2] == 16'h0000) &&
    (prm_q[APO_IX_TFFG] == 16'h0000) && (prm_q[APO_IX_TFFF] == 16'h0000);
  endsequence
  sequence s_gsw_req;
    auto_en_d && !ctrl_q.keep_cur;
  endsequence

  AST_AUTO_EN: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_auto_en == $past(auto_en_d)) else $error("auto enable does not follow mode");
  AST_STIFF_SET: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_stiff_req |=> (prm_q[APO_IX_POS1] == $past(gain.pos1)) &&
      (prm_q[APO_IX_POS2] == $past(gain.pos2)) && (prm_q[APO_IX_FLT2] == $past(gain.flt1)) &&
      (prm_q[APO_IX_INT2] == 16'h2710)) else $error("stiffness gains not applied together");
  AST_POS_RANGE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (prm_q[APO_IX_POS1] <= 16'h7530) && (prm_q[APO_IX_POS2] <= 16'h7530))
    else $error("position gain out of range");
  AST_VEL_RANGE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (prm_q[APO_IX_VEL1] >= 16'h0001) && (prm_q[APO_IX_VEL1] <= 16'h7FFF) &&
    (prm_q[APO_IX_VEL2] >= 16'h0001) && (prm_q[APO_IX_VEL2] <= 16'h7FFF))
    else $error("velocity gain out of range");
  AST_FLT_RANGE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (prm_q[APO_IX_FLT1] <= 16'h09C4) && (prm_q[APO_IX_FLT2] <= 16'h09C4))
    else $error("thrust filter out of range");
  AST_FIXED: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_fixed_req |=> s_fixed_done ##0 (prm_q[APO_IX_VFFG] == 16'h012C) ##0
      (prm_q[APO_IX_VFFF] == 16'h0032)) else $error("fixed parameters not forced");
  AST_GSW_MODE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    auto_en_d |=> prm_q[APO_IX_PMOD] == ($past(ctrl_q.gsw_en) ? 16'h000A : 16'h0000))
    else $error("position switching mode wrong");
  AST_GSW_DEF: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_gsw_req |=> (prm_q[APO_IX_SEL2] == 16'h0001) && (prm_q[APO_IX_PDLY] == 16'h0032) &&
      (prm_q[APO_IX_PHYS] == 16'h0021) && (prm_q[APO_IX_PTIM] == 16'h0021) &&
      (prm_q[APO_IX_VMOD] == 16'h0000) && (prm_q[APO_IX_LAST] == 16'h0000))
    else $error("gain switching defaults not loaded");
  AST_SW_RANGE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (prm_q[APO_IX_VMOD] <= 16'h0005) && (prm_q[APO_IX_TMOD] <= 16'h0003))
    else $error("switching mode out of range");
  AST_OBS_KEEP: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    (auto_en_d && !i_bus.wr) |=> (fexp_q == $past(fexp_q)) && (fexp_eff_q[1:0] == 2'b00))
    else $error("observer setting changed or not masked");
  AST_DOB_OFF: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    o_auto_en |-> !o_obs.dob_en && !o_obs.ivob_en) else $error("observer active in auto-tuning");

  // Switching defaults, mode range, expansion mask and observer ranges.
  AST_SW_ZERO: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_gsw_req |=> (prm_q[APO_IX_LAST:APO_IX_VMOD] == '0))
    else $error("velocity or thrust switching not cleared");
  AST_SEL2_LVL: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    s_gsw_req |=> (prm_q[APO_IX_SEL2] == 16'h0001) && (prm_q[APO_IX_PLVL] == 16'h0032))
    else $error("second gain selection or level not loaded");
  AST_PMOD_RANGE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    prm_q[APO_IX_PMOD] <= 16'h000A) else $error("position switching mode out of range");
  AST_FEXP_MASK: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    auto_en_d |=> (o_fexp_eff[1:0] == 2'b00) && (o_fexp_eff[7:2] == $past(fexp_q[7:2])))
    else $error("expansion bits not masked");
  AST_DOB_RANGE: assert property (@(posedge i_mclk) disable iff (!i_nrst)
    ($signed(dobg_q) >= APO_DOBG_MIN) && ($signed(dobg_q) <= APO_DOBG_MAX) &&
    (dobf_q >= APO_DOBF_MIN) && (dobf_q <= APO_DOBF_MAX))
    else $error("observer setting out of range");

endmodule

//--- apo_pkg.sv
/*
  Constants, register map and carrier types for the auto-tuning parameter override block.
  Assumes a single control clock and a plain register port owned by the drive's software.
*/
package apo_pkg;

  // Bus and storage sizes.
  localparam int APO_AW   = 8;
  localparam int APO_DW   = 16;
  localparam int APO_NPRM = 28;
  localparam int APO_SW   = 5;

  // Register offsets.
  localparam logic [7:0] APO_OFS_MODE  = 8'h00;
  localparam logic [7:0] APO_OFS_STIFF = 8'h01;
  localparam logic [7:0] APO_OFS_CTRL  = 8'h02;
  localparam logic [7:0] APO_OFS_STAT  = 8'h03;
  localparam logic [7:0] APO_OFS_PRM   = 8'h20;
  localparam logic [7:0] APO_OFS_FEXP  = 8'h40;
  localparam logic [7:0] APO_OFS_DOBG  = 8'h41;
  localparam logic [7:0] APO_OFS_DOBF  = 8'h42;

  // Function expansion bit positions.
  localparam int APO_FEXP_IVOB = 0;
  localparam int APO_FEXP_DOB  = 1;

  // Reset values.
  localparam logic [7:0]  APO_MODE_RST  = 8'h00;
  localparam logic [4:0]  APO_STIFF_RST = 5'h00;
  localparam logic [3:0]  APO_CTRL_RST  = 4'hB;
  localparam logic [7:0]  APO_FEXP_RST  = 8'h00;
  localparam logic [15:0] APO_DOBG_RST  = 16'h0000;
  localparam logic [15:0] APO_DOBF_RST  = 16'h000A;

  // Parameter indices inside the gain and switching array.
  localparam int APO_IX_POS1 = 0;
  localparam int APO_IX_VEL1 = 1;
  localparam int APO_IX_INT1 = 2;
  localparam int APO_IX_VDF1 = 3;
  localparam int APO_IX_FLT1 = 4;
  localparam int APO_IX_POS2 = 5;
  localparam int APO_IX_VEL2 = 6;
  localparam int APO_IX_INT2 = 7;
  localparam int APO_IX_VDF2 = 8;
  localparam int APO_IX_FLT2 = 9;
  localparam int APO_IX_VFFG = 10;
  localparam int APO_IX_VFFF = 11;
  localparam int APO_IX_TFFG = 12;
  localparam int APO_IX_TFFF = 13;
  localparam int APO_IX_SEL2 = 14;
  localparam int APO_IX_PMOD = 15;
  localparam int APO_IX_PDLY = 16;
  localparam int APO_IX_PLVL = 17;
  localparam int APO_IX_PHYS = 18;
  localparam int APO_IX_PTIM = 19;
  localparam int APO_IX_VMOD = 20;
  localparam int APO_IX_TMOD = 24;
  localparam int APO_IX_LAST = 27;

  // Values forced by the auto-tuning function.
  localparam logic [15:0] APO_ZERO       = 16'h0000;
  localparam logic [15:0] APO_FIX_VFFG   = 16'h012C;
  localparam logic [15:0] APO_FIX_VFFF   = 16'h0032;
  localparam logic [15:0] APO_INT2_FIX   = 16'h2710;
  localparam logic [15:0] APO_GSW_SEL2   = 16'h0001;
  localparam logic [15:0] APO_GSW_MOD_ON = 16'h000A;
  localparam logic [15:0] APO_GSW_DLY    = 16'h0032;
  localparam logic [15:0] APO_GSW_LVL    = 16'h0032;
  localparam logic [15:0] APO_GSW_HYS    = 16'h0021;
  localparam logic [15:0] APO_GSW_TIM    = 16'h0021;

  // Legal ranges per entry, index 0 first.
  localparam logic [15:0] APO_PRM_MIN [APO_NPRM] = '{
    16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
    16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] APO_PRM_MAX [APO_NPRM] = '{
    16'h7530, 16'h7FFF, 16'h2710, 16'h0005, 16'h09C4, 16'h7530, 16'h7FFF,
    16'h2710, 16'h0005, 16'h09C4, 16'h03E8, 16'h1900, 16'h03E8, 16'h1900,
    16'h0001, 16'h000A, 16'h2710, 16'h4E20, 16'h4E20, 16'h2710, 16'h0005,
    16'h2710, 16'h4E20, 16'h4E20, 16'h0003, 16'h2710, 16'h4E20, 16'h4E20};

  // Disturbance observer ranges; the gain is two's complement.
  localparam logic signed [15:0] APO_DOBG_MIN = 16'shFF9C;
  localparam logic signed [15:0] APO_DOBG_MAX = 16'sh0064;
  localparam logic [15:0]        APO_DOBF_MIN = 16'h000A;
  localparam logic [15:0]        APO_DOBF_MAX = 16'h09C4;

  typedef logic [APO_NPRM-1:0][APO_DW-1:0] apo_prm_t;

  typedef struct packed {
    logic [APO_AW-1:0] addr;
    logic [APO_DW-1:0] wdata;
    logic              wr;
    logic              rd;
  } apo_bus_s;

  typedef struct packed {
    logic gsw_en;
    logic keep_cur;
    logic fixed_valid;
    logic stiff_valid;
  } apo_ctrl_s;

  typedef struct packed {
    logic [15:0] pos1;
    logic [15:0] vel1;
    logic [15:0] int1;
    logic [15:0] flt1;
    logic [15:0] pos2;
  } apo_gain_s;

  typedef struct packed {
    logic dob_en;
    logic ivob_en;
  } apo_obs_s;

endpackage

//--- apo_gain_table.sv
/*
  Stiffness to basic gain lookup for the auto-tuning override block.
  Assumes the caller registers the result; the second velocity gain and filter
  equal the first ones and the second integration constant is fixed.
*/
`timescale 1ns/100ps
module apo_gain_table
  import apo_pkg::*;
(
  // Stiffness setting.
  input  wire logic [APO_SW-1:0] i_stiff,
  // Basic gain set.
  output apo_gain_s              o_gain
);

  always_comb begin
    unique case (i_stiff)
      5'h00: o_gain = '{16'h0014, 16'h000F, 16'h0E74, 16'h05DC, 16'h0019};
      5'h01: o_gain = '{16'h0019, 16'h0014, 16'h0AF0, 16'h044C, 16'h001E};
      5'h02: o_gain = '{16'h001E, 16'h0019, 16'h0898, 16'h0384, 16'h0028};
      5'h03: o_gain = '{16'h0028, 16'h001E, 16'h076C, 16'h0320, 16'h002D};
      5'h04: o_gain = '{16'h002D, 16'h0023, 16'h0640, 16'h0258, 16'h0037};
      5'h05: o_gain = '{16'h0037, 16'h002D, 16'h04B0, 16'h01F4, 16'h0046};
      5'h06: o_gain = '{16'h004B, 16'h003C, 16'h0384, 16'h0190, 16'h005F};
      5'h07: o_gain = '{16'h005F, 16'h004B, 16'h02BC, 16'h012C, 16'h0078};
      5'h08: o_gain = '{16'h0073, 16'h005A, 16'h0258, 16'h012C, 16'h008C};
      5'h09: o_gain = '{16'h008C, 16'h006E, 16'h01F4, 16'h00C8, 16'h00AF};
      5'h0A: o_gain = '{16'h00AF, 16'h008C, 16'h0190, 16'h00C8, 16'h00DC};
      5'h0B: o_gain = '{16'h0140, 16'h00B4, 16'h0136, 16'h007E, 16'h017C};
      5'h0C: o_gain = '{16'h0186, 16'h00DC, 16'h00FA, 16'h0067, 16'h01CC};
      5'h0D: o_gain = '{16'h01E0, 16'h010E, 16'h00D2, 16'h0054, 16'h023A};
      5'h0E: o_gain = '{16'h0276, 16'h015E, 16'h00A0, 16'h0041, 16'h02DA};
      5'h0F: o_gain = '{16'h02D0, 16'h0190, 16'h008C, 16'h0039, 16'h0348};
      5'h10: o_gain = '{16'h0384, 16'h01F4, 16'h0078, 16'h002D, 16'h041A};
      5'h11: o_gain = '{16'h0438, 16'h0258, 16'h006E, 16'h0026, 16'h04EC};
      5'h12: o_gain = '{16'h0546, 16'h02EE, 16'h005A, 16'h001E, 16'h0622};
      5'h13: o_gain = '{16'h0654, 16'h0384, 16'h0050, 16'h0019, 16'h0758};
      5'h14: o_gain = '{16'h080C, 16'h047E, 16'h0046, 16'h0014, 16'h096A};
      5'h15: o_gain = '{16'h09CE, 16'h0578, 16'h003C, 16'h0010, 16'h0B72};
      5'h16: o_gain = '{16'h0BEA, 16'h06A4, 16'h0032, 16'h000D, 16'h0DE8};
      5'h17: o_gain = '{16'h0EBA, 16'h0834, 16'h0028, 16'h000B, 16'h1130};
      5'h18: o_gain = '{16'h118A, 16'h09C4, 16'h0028, 16'h0009, 16'h1478};
      5'h19: o_gain = '{16'h1388, 16'h0AF0, 16'h0023, 16'h0008, 16'h170C};
      5'h1A: o_gain = '{16'h15E0, 16'h0C1C, 16'h001E, 16'h0007, 16'h1964};
      5'h1B: o_gain = '{16'h17D4, 16'h0D48, 16'h001E, 16'h0007, 16'h1BBC};
      5'h1C: o_gain = '{16'h19C8, 16'h0E74, 16'h0019, 16'h0006, 16'h1E14};
      5'h1D: o_gain = '{16'h1C20, 16'h0FA0, 16'h0019, 16'h0006, 16'h20D0};
      5'h1E: o_gain = '{16'h1FA4, 16'h1194, 16'h0014, 16'h0005, 16'h24B8};
      5'h1F: o_gain = '{16'h2328, 16'h1388, 16'h0014, 16'h0005, 16'h2904};
    endcase
  end

endmodule

//--- autotune_param_override_bench.sv
/*
  Self-checking bench for the auto-tuning parameter override block.
  Assumes the design package and the override module are compiled before it.
*/
`timescale 1ns/100ps
module autotune_param_override_bench;
  import apo_pkg::*;

  logic              i_mclk;
  logic              i_nrst;
  apo_bus_s          i_bus;
  logic [APO_DW-1:0] o_rdata;
  apo_prm_t          o_prm;
  logic [7:0]        o_fexp_eff;
  logic [APO_DW-1:0] o_dob_gain;
  logic [APO_DW-1:0] o_dob_filt;
  apo_obs_s          o_obs;
  logic              o_auto_en;
  logic [15:0]       exp_q[$];
  logic              rd_d;
  int                err_total;
  int                num_checks;
  int                n;
  logic [15:0]       v;
  // Expected entries 0 to 27 with stiffness 8 and every override active.
  logic [15:0]       fix_v [APO_NPRM] = '{16'h0073, 16'h005A, 16'h0258, 16'h0000, 16'h012C,
    16'h008C, 16'h005A, 16'h2710, 16'h0000, 16'h012C, 16'h012C, 16'h0032, 16'h0000, 16'h0000,
    16'h0001, 16'h000A, 16'h0032, 16'h0032, 16'h0021, 16'h0021, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // Stiffness rows 0 and 31 for entries 0, 1, 2, 4 and 5.
  logic [15:0]       gtab [2][5] = '{'{16'h0014, 16'h000F, 16'h0E74, 16'h05DC, 16'h0019},
                                     '{16'h2328, 16'h1388, 16'h0014, 16'h0005, 16'h2904}};
  logic [7:0]        stf [2]     = '{8'h00, 8'h1F};
  logic [7:0]        gix [5]     = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05};

  apo_param_override dut (
    .i_mclk     (i_mclk),
    .i_nrst     (i_nrst),
    .i_bus      (i_bus),
    .o_rdata    (o_rdata),
    .o_prm      (o_prm),
    .o_fexp_eff (o_fexp_eff),
    .o_dob_gain (o_dob_gain),
    .o_dob_filt (o_dob_filt),
    .o_obs      (o_obs),
    .o_auto_en  (o_auto_en)
  );

  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] e);
    num_checks++;
    if (got !== e) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_bus <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    op(1'b1, 1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 16'h0000);
  endtask

  task automatic idle(input int k);
    repeat (k) op(1'b0, 1'b0, 8'h00, 16'h0000);
  endtask

  task automatic results;
    $display("Checks %0d, errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Read data stands only in the cycle after the strobe and reads 0 otherwise.
  always @(posedge i_mclk) rd_d <= i_bus.rd;
  always @(negedge i_mclk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) chk(o_rdata, exp_q.pop_front());
    else chk(o_rdata, 16'h0000);
  end

  initial begin
    repeat (5000) @(posedge i_mclk);
    err_total++;
    $display("Error at %0t: timeout", $time);
    results;
  end

  initial begin
    i_nrst = 1'b0;
    i_bus = '0;
    err_total = 0;
    num_checks = 0;
    v = 16'($urandom(32'he4f1));
    repeat (3) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rd(APO_OFS_CTRL, 16'h000B);
    rd(APO_OFS_DOBF, 16'h000A);
    for (int i = 0; i < APO_NPRM; i++) begin
      rd(APO_OFS_PRM + 8'(i), (i inside {1, 2, 6, 7, 11}) ? 16'h0001 : 16'h0000);
    end
    wr(8'h7F, 16'h1234);
    rd(8'h7F, 16'h0000);
    wr(APO_OFS_PRM, 16'hFFFF);
    rd(APO_OFS_PRM, 16'h7530);
    wr(APO_OFS_PRM + 8'h01, 16'h0000);
    rd(APO_OFS_PRM + 8'h01, 16'h0001);
    wr(APO_OFS_PRM + 8'h04, 16'h0BB8);
    rd(APO_OFS_PRM + 8'h04, 16'h09C4);
    wr(APO_OFS_PRM + 8'h14, 16'h0009);
    rd(APO_OFS_PRM + 8'h14, 16'h0005);
    wr(APO_OFS_PRM + 8'h18, 16'h0009);
    rd(APO_OFS_PRM + 8'h18, 16'h0003);
    wr(APO_OFS_PRM + 8'h0F, 16'h000B);
    rd(APO_OFS_PRM + 8'h0F, 16'h000A);
    repeat (4) begin
      v = 16'($urandom);
      wr(APO_OFS_PRM, v);
      rd(APO_OFS_PRM, (v > 16'h7530) ? 16'h7530 : v);
    end
    wr(APO_OFS_FEXP, 16'h00FF);
    wr(APO_OFS_DOBG, 16'hFFCE);
    idle(2);
    rd(APO_OFS_STAT, 16'h03FF);
    for (int i = 0; i < APO_NPRM; i++) wr(APO_OFS_PRM + 8'(i), 16'h0002);
    wr(APO_OFS_STIFF, 16'h0008);
    wr(APO_OFS_MODE, 16'h0003);
    idle(1);
    n = 0;
    while (o_auto_en !== 1'b1 && n < 10) begin
      @(negedge i_mclk);
      n++;
    end
    chk({15'h0000, o_auto_en}, 16'h0001);
    chk(o_prm[APO_IX_POS1], 16'h0073);
    chk(o_prm[APO_IX_VFFG], APO_FIX_VFFG);
    chk(o_prm[APO_IX_PMOD], 16'h000A);
    chk(o_prm[APO_IX_PHYS], 16'h0021);
    chk({14'h0000, o_obs}, 16'h0000);
    for (int i = 0; i < 14; i++) begin
      rd(APO_OFS_PRM + 8'(i), fix_v[i]);
    end
    for (int i = 14; i < APO_NPRM; i++) begin
      rd(APO_OFS_PRM + 8'(i), fix_v[i]);
    end
    rd(APO_OFS_STAT, 16'h04FC);
    rd(APO_OFS_FEXP, 16'h00FF);
    rd(APO_OFS_DOBG, 16'hFFCE);
    wr(APO_OFS_DOBG, 16'h0032);
    rd(APO_OFS_DOBG, 16'h0032);
    wr(APO_OFS_PRM + 8'h0A, 16'h0007);
    rd(APO_OFS_PRM + 8'h0A, 16'h012C);
    rd(APO_OFS_STAT, 16'h04FC);
    for (int k = 0; k < 2; k++) begin
      wr(APO_OFS_STIFF, {8'h00, stf[k]});
      idle(2);
      for (int j = 0; j < 5; j++) rd(APO_OFS_PRM + gix[j], gtab[k][j]);
    end
    wr(APO_OFS_CTRL, 16'h0007);
    idle(2);
    rd(APO_OFS_PRM + 8'h0F, 16'h0000);
    wr(APO_OFS_PRM + 8'h10, 16'h004D);
    rd(APO_OFS_PRM + 8'h10, 16'h004D);
    wr(APO_OFS_CTRL, 16'h0005);
    wr(APO_OFS_PRM + 8'h0A, 16'h0064);
    rd(APO_OFS_PRM + 8'h0A, 16'h0064);
    wr(APO_OFS_CTRL, 16'h0004);
    wr(APO_OFS_PRM, 16'h0123);
    rd(APO_OFS_PRM, 16'h0123);
    wr(APO_OFS_PRM + 8'h0F, 16'h0005);
    rd(APO_OFS_PRM + 8'h0F, 16'h0000);
    wr(APO_OFS_DOBG, 16'h8000);
    wr(APO_OFS_DOBF, 16'hFFFF);
    rd(APO_OFS_DOBG, 16'hFF9C);
    rd(APO_OFS_DOBF, 16'h09C4);
    @(negedge i_mclk);
    chk(o_dob_gain, 16'hFF9C);
    chk(o_dob_filt, 16'h09C4);
    chk({8'h00, o_fexp_eff}, 16'h00FC);
    wr(APO_OFS_DOBF, 16'h0001);
    rd(APO_OFS_DOBF, 16'h000A);
    wr(APO_OFS_MODE, 16'h0000);
    idle(2);
    rd(APO_OFS_STAT, 16'h03FF);
    idle(3);
    @(negedge i_mclk);
    chk({8'h00, o_fexp_eff}, 16'h00FF);
    chk({14'h0000, o_obs}, 16'h0003);
    chk(o_dob_filt, 16'h000A);
    results;
  end
endmodule
